/* File: hdl/mss_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer
  import mss_pkg::*;
#(
  parameter int P_MS_CYCLES = MS_CYCLES,
  parameter int P_SEGS      = 16,
  parameter int P_POS_W     = 32,
  parameter int P_IDLE_W    = 16
)
(
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Register port
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [31:0]        o_rdata,
  // Digital input lines from the controller
  input  wire logic               i_segment_run_trigger,
  input  wire logic               i_segment_select_bit0,
  input  wire logic               i_segment_select_bit1,
  input  wire logic               i_segment_select_bit2,
  input  wire logic               i_segment_select_bit3,
  input  wire logic               i_segment_direction_reverse,
  // Drive internal status
  input  wire logic               i_homing_done,
  input  wire logic               i_move_done,
  // Position command and status outputs
  output logic                    o_cmd_valid,
  output logic signed [P_POS_W-1:0] o_cmd_disp,
  output logic      [4:0]         o_seg_num,
  output logic                    o_running,
  output logic                    o_irq
);

  typedef struct packed {
    logic [5:0]                        sync1;
    logic [5:0]                        sync2;
    logic [5:0]                        sync3;
    logic [5:0]                        filt;
    logic [1:0]                        mode;
    logic                              fall_ign;
    logic                              interval;
    logic                              absolute;
    logic [3:0]                        last;
    logic                              src_en;
    logic [2:0]                        status;
    logic [2:0]                        mask;
    logic [P_SEGS-1:0][P_POS_W-1:0]    pos_tab;
    logic [P_SEGS-1:0][P_IDLE_W-1:0]   idle_tab;
    mss_state_type                     state;
    logic [3:0]                        seg;
    logic [15:0]                       pre;
    logic [P_IDLE_W-1:0]               ms_left;
    logic signed [P_POS_W-1:0]         cmd_pos;
    logic [31:0]                       rdata;
    logic                              irq;
    logic                              cmd_valid;
    logic signed [P_POS_W-1:0]         cmd_disp;
    logic                              running;
    logic [4:0]                        seg_num;
  } mss_st_type;

  mss_st_type st_reg;
  mss_st_type st_next;

  // Segment index from the four select lines; number shown is index plus one
  function automatic logic [3:0] seg_index(input logic [5:0] pins);
    seg_index = pins[PIN_SEL_LSB +: 4];
  endfunction

  // Displacement for one segment
  function automatic logic signed [P_POS_W-1:0] seg_disp(
    input logic signed [P_POS_W-1:0] val,
    input logic                      abs_mode,
    input logic signed [P_POS_W-1:0] cur,
    input logic                      rev
  );
    logic signed [P_POS_W-1:0] d;
    d = abs_mode ? val - cur : val;
    seg_disp = rev ? -d : d;
  endfunction

  logic [5:0]  pins_raw;
  logic        rise;
  logic        fall;
  logic        ms_tick;
  logic [3:0]  sel_now;
  logic        last_seg;

  // Raw pin vector
  assign pins_raw = {i_segment_direction_reverse, i_segment_select_bit3,
                     i_segment_select_bit2, i_segment_select_bit1,
                     i_segment_select_bit0, i_segment_run_trigger};

  // Next state
  always_comb
  begin
    st_next           = st_reg;
    st_next.cmd_valid = 1'b0;
    rise              = 1'b0;
    fall              = 1'b0;
    ms_tick           = 1'b0;
    sel_now           = 4'h0;
    last_seg          = 1'b0;

    // Three-stage synchroniser, level accepted once stages two and three agree
    st_next.sync1 = pins_raw;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int b = 0; b < 6; b++)
    begin
      if (st_reg.sync2[b] == st_reg.sync3[b])
      begin
        st_next.filt[b] = st_reg.sync3[b];
      end
    end
    rise    = st_next.filt[PIN_TRIG] & ~st_reg.filt[PIN_TRIG];
    fall    = ~st_next.filt[PIN_TRIG] & st_reg.filt[PIN_TRIG];
    sel_now = seg_index(st_reg.filt);

    // Register writes
    if (i_wr)
    begin
      case (i_addr)
        OFS_CTRL:
        begin
          st_next.mode     = i_wdata[CTRL_MODE_LSB +: 2];
          st_next.fall_ign = i_wdata[CTRL_FALL_IGN];
          st_next.interval = i_wdata[CTRL_INTERVAL];
          st_next.absolute = i_wdata[CTRL_ABSOLUTE];
          st_next.last     = i_wdata[CTRL_LAST_LSB +: 4];
          st_next.src_en   = i_wdata[CTRL_SRC_EN];
        end
        OFS_STATUS: st_next.status = st_reg.status & ~i_wdata[2:0];
        OFS_MASK:   st_next.mask   = i_wdata[2:0];
        default:
        begin
          if (i_addr[7:6] == OFS_POS_BASE[7:6])
          begin
            st_next.pos_tab[i_addr[5:2]] = i_wdata[P_POS_W-1:0];
          end
          else if (i_addr[7:6] == OFS_IDL_BASE[7:6])
          begin
            st_next.idle_tab[i_addr[5:2]] = i_wdata[P_IDLE_W-1:0];
          end
        end
      endcase
    end

    // Millisecond prescaler for idle time
    if (st_reg.state == S_WAIT_IDLE && st_reg.ms_left != '0)
    begin
      if (st_reg.pre == 16'(P_MS_CYCLES - 1))
      begin
        st_next.pre     = 16'h0000;
        st_next.ms_left = st_reg.ms_left - 1'b1;
        ms_tick         = 1'b1;
      end
      else
      begin
        st_next.pre = st_reg.pre + 16'h0001;
      end
    end

    last_seg = (st_reg.seg == st_reg.last);

    // Sequencer
    case (st_reg.state)
      S_IDLE:
      begin
        if (rise && st_reg.src_en)
        begin
          st_next.seg   = (st_reg.mode == MODE_INPUT) ? sel_now : 4'h0;
          st_next.state = S_ISSUE;
        end
      end
      S_ISSUE:
      begin
        if (st_reg.absolute && !i_homing_done)
        begin
          st_next.status[ST_FAULT] = 1'b1;
          st_next.state            = S_IDLE;
        end
        else
        begin
          st_next.cmd_valid = 1'b1;
          st_next.cmd_disp  = seg_disp(st_reg.pos_tab[st_reg.seg], st_reg.absolute,
                                       st_reg.cmd_pos, st_reg.filt[PIN_DIR]);
          st_next.cmd_pos   = st_reg.cmd_pos + st_next.cmd_disp;
          st_next.status[ST_ISSUE] = 1'b1;
          st_next.pre       = 16'h0000;
          st_next.ms_left   = st_reg.idle_tab[st_reg.seg];
          // Interval 0 waits for completion, 1 starts idle at issue
          st_next.state     = st_reg.interval ? S_WAIT_IDLE : S_WAIT_DONE;
        end
      end
      S_WAIT_DONE:
      begin
        if (i_move_done)
        begin
          st_next.pre     = 16'h0000;
          st_next.ms_left = st_reg.idle_tab[st_reg.seg];
          st_next.state   = S_WAIT_IDLE;
        end
      end
      S_WAIT_IDLE:
      begin
        if (st_reg.ms_left == '0)
        begin
          case (st_reg.mode)
            MODE_CYCLIC:
            begin
              st_next.seg   = last_seg ? 4'h0 : st_reg.seg + 4'h1;
              st_next.state = S_ISSUE;
            end
            MODE_INPUT:
            begin
              st_next.state = S_WAIT_SEL;
            end
            default:
            begin
              if (last_seg)
              begin
                st_next.status[ST_DONE] = 1'b1;
                st_next.state           = S_IDLE;
              end
              else
              begin
                st_next.seg   = st_reg.seg + 4'h1;
                st_next.state = S_ISSUE;
              end
            end
          endcase
        end
      end
      S_WAIT_SEL:
      begin
        if (sel_now != st_reg.seg)
        begin
          st_next.seg   = sel_now;
          st_next.state = S_ISSUE;
        end
      end
      default: st_next.state = S_IDLE;
    endcase

    // Falling edge stops only when the edge setting is 0
    if (fall && !st_reg.fall_ign && st_reg.state != S_IDLE)
    begin
      st_next.state     = S_IDLE;
      st_next.cmd_valid = 1'b0;
    end
    // With the setting at 1 the fall is simply not acted on

    // Until homing is done, absolute mode holds the commanded origin at zero
    if (!i_homing_done)
    begin
      st_next.cmd_pos = st_reg.absolute ? '0 : st_next.cmd_pos;
    end

    // Sticky status bits: hardware set wins over a clear in the same cycle only for a bit not already set
    if (i_wr && i_addr == OFS_STATUS)
    begin
      st_next.status = (st_reg.status & ~i_wdata[2:0]) |
                       (st_next.status & ~st_reg.status);
    end

    st_next.running = (st_next.state != S_IDLE);
    // Segment number registered so the output comes from a flip-flop
    st_next.seg_num = {1'b0, st_next.seg} + 5'h01;
    st_next.irq     = |(st_next.status & st_next.mask);

    // Read data, valid the cycle after the strobe
    st_next.rdata = 32'h00000000;
    if (i_rd)
    begin
      case (i_addr)
        OFS_CTRL:
        begin
          st_next.rdata[CTRL_MODE_LSB +: 2] = st_reg.mode;
          st_next.rdata[CTRL_FALL_IGN]      = st_reg.fall_ign;
          st_next.rdata[CTRL_INTERVAL]      = st_reg.interval;
          st_next.rdata[CTRL_ABSOLUTE]      = st_reg.absolute;
          st_next.rdata[CTRL_LAST_LSB +: 4] = st_reg.last;
          st_next.rdata[CTRL_SRC_EN]        = st_reg.src_en;
        end
        OFS_STATUS: st_next.rdata[2:0] = st_reg.status;
        OFS_MASK:   st_next.rdata[2:0] = st_reg.mask;
        OFS_STATE:  st_next.rdata[15:0] = {st_reg.filt, i_homing_done, st_reg.running,
                                           st_reg.seg, 1'b0, st_reg.state};
        default:
        begin
          if (i_addr[7:6] == OFS_POS_BASE[7:6])
          begin
            st_next.rdata[P_POS_W-1:0] = st_reg.pos_tab[i_addr[5:2]];
          end
          else if (i_addr[7:6] == OFS_IDL_BASE[7:6])
          begin
            st_next.rdata[P_IDLE_W-1:0] = st_reg.idle_tab[i_addr[5:2]];
          end
        end
      endcase
    end

    // Synchronous reset of control state
    if (i_rst)
    begin
      st_next          = '0;
      st_next.mode     = RST_MODE;
      st_next.last     = RST_LAST;
      st_next.status   = RST_STATUS;
      st_next.mask     = RST_MASK;
      st_next.state    = S_IDLE;
      st_next.seg_num  = 5'h01;
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    st_reg <= st_next;
  end

  // Outputs straight from the state register
  assign o_rdata     = st_reg.rdata;
  assign o_cmd_valid = st_reg.cmd_valid;
  assign o_cmd_disp  = st_reg.cmd_disp;
  assign o_seg_num   = st_reg.seg_num;
  assign o_running   = st_reg.running;
  assign o_irq       = st_reg.irq;

endmodule
`default_nettype wire

/* File: common/mss_pkg.sv */
`default_nettype none
package mss_pkg;

  // Clock and idle time base
  localparam int CLK_HZ       = 20000000;
  localparam int IDLE_UNIT_US = 1000;
  localparam int MS_CYCLES    = CLK_HZ / 1000000 * IDLE_UNIT_US;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_STATE    = 8'h0c;
  localparam logic [7:0] OFS_POS_BASE = 8'h40;
  localparam logic [7:0] OFS_IDL_BASE = 8'h80;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FALL_IGN = 2;
  localparam int CTRL_INTERVAL = 3;
  localparam int CTRL_ABSOLUTE = 4;
  localparam int CTRL_LAST_LSB = 8;
  localparam int CTRL_SRC_EN   = 12;

  // Status and mask bit positions
  localparam int ST_FAULT = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_ISSUE = 2;

  // Reset values
  localparam logic [1:0]  RST_MODE   = 2'h0;
  localparam logic [3:0]  RST_LAST   = 4'h0;
  localparam logic [2:0]  RST_STATUS = 3'h0;
  localparam logic [2:0]  RST_MASK   = 3'h0;

  // Pin vector positions after synchronisation
  localparam int PIN_TRIG    = 0;
  localparam int PIN_SEL_LSB = 1;
  localparam int PIN_DIR     = 5;

  // Run modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_CYCLIC = 2'h1;
  localparam logic [1:0] MODE_INPUT  = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ISSUE,
    S_WAIT_DONE,
    S_WAIT_IDLE,
    S_WAIT_SEL
  } mss_state_type;

endpackage
`default_nettype wire

/* File: verif/mss_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_properties
  import mss_pkg::*;
#(
  parameter int P_POS_W = 32
)
(
  // Watched ports
  input wire logic                      i_clk,
  input wire logic                      i_rst,
  input wire logic [7:0]                i_addr,
  input wire logic [31:0]               i_wdata,
  input wire logic                      i_wr,
  input wire logic                      i_rd,
  input wire logic [31:0]               o_rdata,
  input wire logic                      i_segment_run_trigger,
  input wire logic                      o_cmd_valid,
  input wire logic signed [P_POS_W-1:0] o_cmd_disp,
  input wire logic [4:0]                o_seg_num,
  input wire logic                      o_running,
  input wire logic                      o_irq
);
  // Control clock, quiet during reset except reset_out_a
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  issue_gap_a: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command pulses too close");
  disp_hold_a: assert property (!o_cmd_valid |-> $stable(o_cmd_disp))
    else $error("displacement moved without a command");
  seg_range_a: assert property (o_seg_num >= 5'h01 && o_seg_num <= 5'h10)
    else $error("segment number out of range");
  valid_run_a: assert property (o_cmd_valid |-> o_running)
    else $error("command while stopped");
  sync_delay_a: assert property (
    $rose(i_segment_run_trigger) && !o_running |-> !o_cmd_valid [*3])
    else $error("trigger acted before synchronising");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  mask_off_a: assert property (
    i_wr && i_addr == OFS_MASK && i_wdata[2:0] == 3'h0 |-> ##[1:2] !o_irq)
    else $error("interrupt stayed with mask cleared");
  reset_out_a: assert property (
    disable iff (1'b0) i_rst |=> o_seg_num == 5'h01 && !o_running && !o_irq)
    else $error("outputs not at reset state");
endmodule
`default_nettype wire

/* File: verif/mss_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mss_ctrl_model
(
  // Clock
  input  wire logic i_clk,
  // Digital input lines toward the drive
  output var logic  o_segment_run_trigger,
  output var logic  o_segment_select_bit0,
  output var logic  o_segment_select_bit1,
  output var logic  o_segment_select_bit2,
  output var logic  o_segment_select_bit3,
  output var logic  o_segment_direction_reverse
);
  // Lines start inactive
  initial
  begin
    o_segment_run_trigger = 1'b0;
    o_segment_direction_reverse = 1'b0;
    {o_segment_select_bit3, o_segment_select_bit2} = 2'h0;
    {o_segment_select_bit1, o_segment_select_bit0} = 2'h0;
  end
  // Drive assigned lines just after an edge, then hold them
  task automatic set_lines(input logic t, input logic [3:0] s, input logic d);
    @(posedge i_clk);
    o_segment_run_trigger <= t;
    {o_segment_select_bit3, o_segment_select_bit2} <= s[3:2];
    {o_segment_select_bit1, o_segment_select_bit0} <= s[1:0];
    o_segment_direction_reverse <= d;
  endtask
endmodule
`default_nettype wire

/* File: verif/mss_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mss_sequencer_tb_top
  import mss_pkg::*;
  ();
  typedef struct {logic [31:0] val; logic dir; logic [31:0] exp;} mss_row_type;
  // Bench signals
  logic        i_clk;
  logic        i_rst;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_homing_done;
  logic        i_move_done;
  logic [31:0] o_rdata;
  logic        o_cmd_valid;
  logic [31:0] o_cmd_disp;
  logic [4:0]  o_seg_num;
  logic        o_running;
  logic        o_irq;
  logic        trig;
  logic [3:0]  sel;
  logic        dir;
  int          failures;
  int          num_checks;
  mss_row_type rows [4] = '{'{32'h3e8, 1'b0, 32'h3e8}, '{32'hfffffc18, 1'b0, 32'hfffffc18},
                            '{32'h7d0, 1'b1, 32'hfffff830}, '{32'hfffffffb, 1'b1, 32'h5}};
  // Controller and design
  mss_ctrl_model mss_ctrl_model_inst (.i_clk(i_clk), .o_segment_run_trigger(trig),
    .o_segment_select_bit0(sel[0]), .o_segment_select_bit1(sel[1]),
    .o_segment_select_bit2(sel[2]), .o_segment_select_bit3(sel[3]),
    .o_segment_direction_reverse(dir));
  mss_sequencer #(.P_MS_CYCLES(4)) mss_sequencer_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_segment_run_trigger(trig), .i_segment_select_bit0(sel[0]),
    .i_segment_select_bit1(sel[1]), .i_segment_select_bit2(sel[2]),
    .i_segment_select_bit3(sel[3]), .i_segment_direction_reverse(dir),
    .i_homing_done(i_homing_done), .i_move_done(i_move_done), .o_cmd_valid(o_cmd_valid),
    .o_cmd_disp(o_cmd_disp), .o_seg_num(o_seg_num), .o_running(o_running), .o_irq(o_irq));
  // Clock and motion finishing a cycle after each command
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) i_move_done <= o_cmd_valid;
  // Helpers
  task automatic end_sim();
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic pins(input logic t, input logic [3:0] s, input logic d);
    mss_ctrl_model_inst.set_lines(t, s, d);
  endtask
  // Wait for a command pulse, or for the run to end
  task automatic wait_on(input bit run);
    int n;
    for (n = 0; n < 300; n++)
    begin
      tick(1);
      if (run ? o_running === 1'b0 : o_cmd_valid === 1'b1)
        break;
    end
    if (n == 300)
    begin
      failures++;
      end_sim();
    end
  endtask
  task automatic cmd(input logic [31:0] disp, input logic [31:0] seg);
    wait_on(1'b0);
    chk(o_cmd_disp, disp);
    chk({27'h0, o_seg_num}, seg);
  endtask
  // Main sequence
  initial
  begin
    i_rst = 1'b1;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_homing_done = 1'b0;
    i_move_done = 1'b0;
    failures = 0;
    num_checks = 0;
    tick(5);
    i_rst <= 1'b0;
    tick(1);
    chk({27'h0, o_seg_num}, 32'h1);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_CTRL, 32'h100c);
    foreach (rows[k])
    begin
      wr(OFS_POS_BASE, rows[k].val);
      pins(1'b0, 4'h0, rows[k].dir);
      tick(6);
      pins(1'b1, 4'h0, rows[k].dir);
      cmd(rows[k].exp, 32'h1);
      wait_on(1'b1);
    end
    // Absolute target refused before homing, fault on the interrupt
    pins(1'b0, 4'h0, 1'b0);
    wr(OFS_STATUS, 32'h7);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h101c);
    pins(1'b1, 4'h0, 1'b0);
    tick(12);
    rd(OFS_STATUS, 32'h1);
    chk({31'h0, o_running | o_irq}, 32'h0);
    wr(OFS_MASK, 32'h1);
    tick(3);
    chk({31'h0, o_irq}, 32'h1);
    wr(OFS_STATUS, 32'h1);
    tick(3);
    chk({31'h0, o_irq}, 32'h0);
    // Cyclic run ignoring the falling edge
    pins(1'b0, 4'h0, 1'b0);
    wr(OFS_CTRL, 32'h110d);
    pins(1'b1, 4'h0, 1'b0);
    cmd(32'hfffffffb, 32'h1);
    pins(1'b0, 4'h0, 1'b0);
    cmd(32'h0, 32'h2);
    cmd(32'hfffffffb, 32'h1);
    // Reset mid-run, then absolute run after homing
    i_rst <= 1'b1;
    tick(2);
    i_rst <= 1'b0;
    i_homing_done <= 1'b1;
    wr(OFS_CTRL, 32'h121c);
    wr(OFS_POS_BASE, 32'h3e8);
    wr(OFS_POS_BASE + 8'h4, 32'h7d0);
    pins(1'b1, 4'h0, 1'b0);
    cmd(32'h3e8, 32'h1);
    cmd(32'h3e8, 32'h2);
    cmd(32'hfffff830, 32'h3);
    wait_on(1'b1);
    rd(OFS_STATUS, 32'h6);
    // Input-selected run, stopped by the falling edge
    pins(1'b0, 4'h5, 1'b0);
    wr(OFS_CTRL, 32'h100a);
    wr(OFS_POS_BASE + 8'h14, 32'h12c);
    wr(OFS_POS_BASE + 8'h28, 32'hfffffff9);
    pins(1'b1, 4'h5, 1'b0);
    cmd(32'h12c, 32'h6);
    pins(1'b1, 4'ha, 1'b0);
    cmd(32'hfffffff9, 32'hb);
    pins(1'b0, 4'ha, 1'b0);
    wait_on(1'b1);
    // Interval 0: wait for completion, then one idle millisecond
    wr(OFS_CTRL, 32'h1100);
    wr(OFS_IDL_BASE, 32'h1);
    pins(1'b1, 4'h0, 1'b0);
    cmd(32'h3e8, 32'h1);
    tick(7);
    chk({31'h0, o_cmd_valid}, 32'h0);
    tick(1);
    chk({31'h0, o_cmd_valid}, 32'h1);
    chk(o_cmd_disp, 32'h7d0);
    wait_on(1'b1);
    end_sim();
  end
endmodule
bind mss_sequencer mss_sequencer_properties #(.P_POS_W(P_POS_W)) mss_sequencer_properties_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_segment_run_trigger(i_segment_run_trigger),
  .o_cmd_valid(o_cmd_valid), .o_cmd_disp(o_cmd_disp), .o_seg_num(o_seg_num),
  .o_running(o_running), .o_irq(o_irq));
`default_nettype wire
